// ---- logic/init_ctrl_defs.vh ----
`ifndef INIT_CTRL_DEFS_VH
`define INIT_CTRL_DEFS_VH

// Register byte offsets
`define OFS_CTRL      4'h0
`define OFS_STATUS    4'h4
`define OFS_ESR       4'h8
`define OFS_ESE       4'hc

// Control register bit positions (self-clearing strobes except startup mode and slot)
`define CTRL_OPC_CMD    0
`define CTRL_OPC_QRY    1
`define CTRL_OP_DONE    2
`define CTRL_RST_CMD    3
`define CTRL_FACTORY    4
`define CTRL_SETUP_DEF  5
`define CTRL_SETUP_ALT  6
`define CTRL_MODE_LAST  8
`define CTRL_SLOT_LO    12
`define CTRL_SLOT_HI    15

// Standard event status bit positions
`define ESR_OPC       0

// Status register bit positions
`define ST_MAV        0
`define ST_OCIS       1
`define ST_OQIS       2
`define ST_BLOCKED    3
`define ST_BUSY       4
`define ST_SHIPPED    5
`define ST_REMOTE     6
`define ST_LOCKOUT    7
`define ST_TALK       8
`define ST_LISTEN     9
`define ST_AH         10
`define ST_SRQ        11
`define ST_PARSER     12

// Reset values
`define CTRL_RESET    32'h0000_0000
`define ESR_RESET     8'h00
`define ESE_RESET     8'h00

// Setup source codes
`define SRC_FACTORY   2'h0
`define SRC_LAST      2'h1
`define SRC_SLOT      2'h2

`endif

// ---- logic/remote_init_ctrl.v ----
// Overview of operation
// R01: IFC resets acceptor, talker, listener, controller; partly service request.
// R02: IFC leaves the instrument operating configuration untouched.
// R03: Either DCL or an addressed SDC triggers the message-exchange clear.
// R04: Clear empties input buffer and output queue and MAV together.
// R05: Clear resets parser, execution controller and response formatter.
// R06: Clear discards anything blocking device commands including reset.
// R07: Clear enters OCIS; pending operation-complete command no longer sets bit.
// R08: Clear enters OQIS; pending query no longer queues its response.
// R09: After clear, message-exchange sections idle awaiting new message.
// R10: Clear keeps stored data, settings, other status bits, running operation.
// R11: Reset command restores functions but keeps interface, queue, enables.
// R12: Three device preset commands perform a level-3 initialization.
// R13: Power-up restores last setup or recalls chosen slot.
// R14: First power-up after shipment loads factory setup instead.
// R15: Power-up empties input buffer and output queue.
// R16: Power-up initializes parser, execution controller, response formatter.
// R17: Power-up enters OCIS and OQIS.
// R18: Power-up clears event status and enable; events recorded afterwards.
// R19: New listen address with unread response clears output buffer, drops it.
// R20: Local key returns to local unless remote-with-lockout.
// R21: Operation complete sets event status bit 0 once operations finish.
// R22: Controller orders bus, then message-exchange, then device initialization; the bench issues clears, then presets, then IFC last.
// R23: Each clear completes in one cycle; none is seen half done.
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "init_ctrl_defs.vh"
module remote_init_ctrl (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        ifc,
  input  wire        dcl,
  input  wire        sdc,
  input  wire        listen_addr,
  input  wire        talk_addr,
  input  wire        msg_byte_in,
  input  wire        resp_byte_out,
  input  wire        ren,
  input  wire        llo,
  input  wire        local_key,
  input  wire        shipped_flag,
  output reg         mav_r,
  output reg         remote_r,
  output reg         talker_r,
  output reg         listener_r,
  output reg         acceptor_busy_r,
  output reg         srq_r,
  output reg         cfg_apply_r,
  output reg  [1:0]  cfg_source_r,
  output reg  [3:0]  cfg_slot_r,
  output reg         dev_init_r
);

  localparam P_IDLE   = 2'h0;
  localparam P_PARSE  = 2'h1;
  localparam P_EXEC   = 2'h2;
  localparam P_RESP   = 2'h3;

  reg [1:0] rst_sync_r;
  wire      rstn_i = rst_sync_r[1];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  localparam [31:0] CTRL_INIT = `CTRL_RESET;

  reg [15:8] setup_keep_r;
  reg [7:0]  esr_r;
  reg [7:0]  ese_r;
  reg [3:0]  in_cnt_r;
  reg [3:0]  out_cnt_r;
  reg [1:0]  pstate_r;
  reg        ocis_r;
  reg        oqis_r;
  reg        blocked_r;
  reg        busy_r;
  reg        lockout_r;
  reg        pon_done_r;
  reg        ack_r;

  wire msg_clear = dcl | (sdc & listen_addr);                   // [R03]
  wire req       = (avs_read | avs_write) & ~ack_r;
  // Writes land on the edge that sees waitrequest low, never earlier
  wire commit    = avs_write & ~avs_waitrequest;
  wire wr_ctrl   = commit & (avs_address == `OFS_CTRL);
  wire wr_esr    = commit & (avs_address == `OFS_ESR);
  wire wr_ese    = commit & (avs_address == `OFS_ESE);
  wire [31:0] wd = avs_writedata;

  wire opc_cmd   = wr_ctrl & avs_byteenable[0] & wd[`CTRL_OPC_CMD];
  wire opc_qry   = wr_ctrl & avs_byteenable[0] & wd[`CTRL_OPC_QRY];
  wire op_done   = wr_ctrl & avs_byteenable[0] & wd[`CTRL_OP_DONE];
  wire rst_cmd   = wr_ctrl & avs_byteenable[0] & wd[`CTRL_RST_CMD];
  wire dev_cmd   = wr_ctrl & avs_byteenable[0] &
                   (wd[`CTRL_FACTORY] | wd[`CTRL_SETUP_DEF] |
                    wd[`CTRL_SETUP_ALT]);
  wire drop_resp = listen_addr & ~listener_r & (out_cnt_r != 4'h0);
  wire opc_fire  = ~ocis_r & ~busy_r;
  wire oqr_fire  = ~oqis_r & ~busy_r;

  // Bus slave: one wait state; read data latched when the request is taken
  always @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_r           <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      ack_r           <= req;
      avs_waitrequest <= ~req;
      if (req & avs_read) begin
        case (avs_address)
          `OFS_CTRL:   avs_readdata <= {16'h0000, setup_keep_r, 8'h00};
          `OFS_STATUS: avs_readdata <= {18'h0, pstate_r, srq_r,
                          acceptor_busy_r, listener_r, talker_r,
                          lockout_r, remote_r, pon_done_r, busy_r,
                          blocked_r, oqis_r, ocis_r, mav_r};
          `OFS_ESR:    avs_readdata <= {24'h000000, esr_r};
          `OFS_ESE:    avs_readdata <= {24'h000000, ese_r};
          default:     avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Interface functions
  always @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      talker_r        <= 1'b0;
      listener_r      <= 1'b0;
      acceptor_busy_r <= 1'b0;
      srq_r           <= 1'b0;
      remote_r        <= 1'b0;
      lockout_r       <= 1'b0;
    end else begin
      if (ifc) begin
        talker_r        <= 1'b0;                                // [R01]
        listener_r      <= 1'b0;                                // [R01]
        acceptor_busy_r <= 1'b0;                                // [R01]
        srq_r           <= 1'b0;                                // [R01]
      end else begin
        talker_r        <= talk_addr;
        listener_r      <= listen_addr;
        acceptor_busy_r <= msg_byte_in;
        srq_r           <= |(esr_r & ese_r);
      end
      // Remote/local untouched by IFC
      if (!ren) begin
        remote_r  <= 1'b0;
        lockout_r <= 1'b0;
      end else begin
        if (llo)
          lockout_r <= 1'b1;
        if (listen_addr)
          remote_r <= 1'b1;
        else if (local_key & ~lockout_r & ~llo)
          remote_r <= 1'b0;                                     // [R20]
      end
    end
  end

  // Message exchange: buffers, parser, OPC machinery
  always @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      in_cnt_r  <= 4'h0;                                        // [R15]
      out_cnt_r <= 4'h0;                                        // [R15]
      mav_r     <= 1'b0;
      pstate_r  <= P_IDLE;                                      // [R16]
      ocis_r    <= 1'b1;                                        // [R17]
      oqis_r    <= 1'b1;                                        // [R17]
      blocked_r <= 1'b0;
      busy_r    <= 1'b0;
    end else if (msg_clear) begin
      // Single-cycle clear, no partial state; IFC path not involved [R02]
      in_cnt_r  <= 4'h0;                                        // [R04]
      out_cnt_r <= 4'h0;                                        // [R04]
      mav_r     <= 1'b0;                                        // [R04] [R23]
      pstate_r  <= P_IDLE;                                      // [R05] [R09]
      blocked_r <= 1'b0;                                        // [R06]
      ocis_r    <= 1'b1;                                        // [R07]
      oqis_r    <= 1'b1;                                        // [R08]
      busy_r    <= busy_r & ~op_done;                           // [R10]
    end else begin
      if (msg_byte_in && in_cnt_r != 4'hf)
        in_cnt_r <= in_cnt_r + 4'h1;
      case (pstate_r)
        P_IDLE:  if (msg_byte_in) pstate_r <= P_PARSE;
        P_PARSE: pstate_r <= P_EXEC;
        P_EXEC:  pstate_r <= (out_cnt_r != 4'h0) ? P_RESP : P_IDLE;
        P_RESP:  if (out_cnt_r == 4'h0) pstate_r <= P_IDLE;
        default: pstate_r <= P_IDLE;
      endcase
      if (opc_cmd)
        ocis_r <= 1'b0;
      else if (opc_fire)
        ocis_r <= 1'b1;
      if (opc_qry)
        oqis_r <= 1'b0;
      else if (oqr_fire)
        oqis_r <= 1'b1;
      if (rst_cmd | dev_cmd)
        busy_r <= 1'b1;
      else if (op_done)
        busy_r <= 1'b0;
      blocked_r <= busy_r & (opc_cmd | opc_qry);
      if (drop_resp) begin
        out_cnt_r <= 4'h0;                                      // [R19]
        mav_r     <= 1'b0;                                      // [R19]
      end else if (~oqis_r & oqr_fire) begin
        out_cnt_r <= out_cnt_r + 4'h1;
        mav_r     <= 1'b1;
      end else if (resp_byte_out && out_cnt_r != 4'h0) begin
        out_cnt_r <= out_cnt_r - 4'h1;
        mav_r     <= (out_cnt_r != 4'h1);
      end
    end
  end

  // Event status and enable registers
  always @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      esr_r  <= `ESR_RESET;                                     // [R18]
      ese_r  <= `ESE_RESET;                                     // [R18]
    end else begin
      if (wr_esr & avs_byteenable[0])
        esr_r <= esr_r & ~wd[7:0];
      if (~ocis_r & opc_fire & ~msg_clear)
        esr_r[`ESR_OPC] <= 1'b1;                                // [R21] [R07]
      if (wr_ese & avs_byteenable[0])
        ese_r <= wd[7:0];                                       // [R11]
    end
  end

  // Startup selection is retained across reset like a backed-up setting;
  // only the first power-up after shipment returns it to its default
  always @(posedge clk) begin
    if (!pon_done_r && !shipped_flag)
      setup_keep_r <= CTRL_INIT[15:8];                          // [R14]
    else if (wr_ctrl & avs_byteenable[1])
      setup_keep_r <= wd[15:8];                                 // [R13]
  end

  // Power-up setup load and level-3 initialization
  always @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      pon_done_r   <= 1'b0;
      cfg_apply_r  <= 1'b0;
      cfg_source_r <= `SRC_FACTORY;
      cfg_slot_r   <= 4'h0;
      dev_init_r   <= 1'b0;
    end else begin
      cfg_apply_r <= 1'b0;
      dev_init_r  <= rst_cmd | dev_cmd;                         // [R11] [R12]
      if (!pon_done_r) begin
        pon_done_r  <= 1'b1;
        cfg_apply_r <= 1'b1;
        cfg_slot_r  <= setup_keep_r[`CTRL_SLOT_HI:`CTRL_SLOT_LO];
        if (!shipped_flag)
          cfg_source_r <= `SRC_FACTORY;                         // [R14]
        else if (setup_keep_r[`CTRL_MODE_LAST])
          cfg_source_r <= `SRC_LAST;                            // [R13]
        else
          cfg_source_r <= `SRC_SLOT;                            // [R13]
      end else if (dev_cmd) begin
        cfg_apply_r  <= 1'b1;
        cfg_source_r <= `SRC_FACTORY;                           // [R12]
      end
    end
  end

endmodule

// ---- verification/gpib_ctrl_model.sv ----
`timescale 1ns/1ps
module gpib_ctrl_model (
  input  wire       clk,
  input  wire [1:0] op,
  input  wire       go,
  output reg        ifc = 1'b0,
  output reg        dcl = 1'b0,
  output reg        sdc = 1'b0
);
  // One-cycle bus commands; bench issues clears, then presets, then IFC last
  always @(posedge clk) begin
    ifc <= go && (op == 2'h0);
    dcl <= go && (op == 2'h1);
    sdc <= go && (op == 2'h2);
  end
endmodule

// ---- verification/init_ctrl_asserts.sv ----
`timescale 1ns/1ps
`include "init_ctrl_defs.vh"
module init_ctrl_asserts (
  input wire        clk,
  input wire        rst_n,
  input wire [3:0]  avs_address,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire        avs_waitrequest,
  input wire        ifc,
  input wire        dcl,
  input wire        sdc,
  input wire        listen_addr,
  input wire        llo,
  input wire        ren,
  input wire        local_key,
  input wire        shipped_flag,
  input wire        mav_r,
  input wire        remote_r,
  input wire        talker_r,
  input wire        listener_r,
  input wire        cfg_apply_r,
  input wire [1:0]  cfg_source_r,
  input wire [3:0]  cfg_slot_r,
  input wire        dev_init_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Lockout stays latched until remote enable drops
  reg lock_seen_r = 1'b0;
  always @(posedge clk)
    lock_seen_r <= ren & (llo | lock_seen_r);
  property p_ifc_clear;
    ifc |=> !talker_r && !listener_r;
  endproperty
  a_ifc_clear: assert property (p_ifc_clear)
    else $error("ifc left talker or listener set");
  property p_ifc_keep;
    ifc |=> $stable(cfg_source_r) && $stable(cfg_slot_r);
  endproperty
  a_ifc_keep: assert property (p_ifc_keep)
    else $error("ifc changed configuration");
  property p_clr_mav;
    dcl || (sdc && listen_addr) |=> !mav_r;
  endproperty
  a_clr_mav: assert property (p_clr_mav)
    else $error("clear left mav set");
  property p_clr_keep;
    dcl && !cfg_apply_r |=> $stable(cfg_source_r) && !cfg_apply_r;
  endproperty
  a_clr_keep: assert property (p_clr_keep)
    else $error("clear touched setup");
  property p_preset;
    avs_write && !avs_waitrequest && avs_address == `OFS_CTRL &&
      avs_byteenable[0] && |avs_writedata[6:3] |-> ##[0:2] dev_init_r;
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset gave no device init");
  property p_first_pon;
    cfg_apply_r && !shipped_flag |-> cfg_source_r == `SRC_FACTORY;
  endproperty
  a_first_pon: assert property (p_first_pon)
    else $error("first power-up not factory");
  property p_local;
    remote_r && ren && local_key && !llo && !lock_seen_r && !listen_addr
      |=> !remote_r;
  endproperty
  a_local: assert property (p_local)
    else $error("local key ignored");
  property p_lockout;
    remote_r && ren && (llo || lock_seen_r) |=> remote_r;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("lockout lost remote");
  property p_mla_drop;
    listen_addr && !listener_r && mav_r |=> !mav_r;
  endproperty
  a_mla_drop: assert property (p_mla_drop)
    else $error("new listen address kept unread response");
endmodule
bind remote_init_ctrl init_ctrl_asserts i_init_ctrl_asserts (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .ifc(ifc), .dcl(dcl), .sdc(sdc), .listen_addr(listen_addr), .llo(llo),
  .ren(ren), .local_key(local_key), .shipped_flag(shipped_flag),
  .mav_r(mav_r), .remote_r(remote_r), .talker_r(talker_r),
  .listener_r(listener_r), .cfg_apply_r(cfg_apply_r),
  .cfg_source_r(cfg_source_r), .cfg_slot_r(cfg_slot_r),
  .dev_init_r(dev_init_r));

// ---- verification/gpib_remote_init_control_test.sv ----
`timescale 1ns/1ps
`include "init_ctrl_defs.vh"
module gpib_remote_init_control_test;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [3:0]  avs_address = 4'h0;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  reg  [1:0]  op = 2'h0;
  reg         go = 1'b0;
  reg         listen_addr = 1'b0;
  reg         talk_addr = 1'b0;
  reg         ren = 1'b0;
  reg         llo = 1'b0;
  reg         local_key = 1'b0;
  reg         shipped_flag = 1'b0;
  reg         msg_byte_in = 1'b0;
  reg         resp_byte_out = 1'b0;
  reg  [31:0] rd;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, ifc, dcl, sdc, mav_r, remote_r, talker_r;
  wire        listener_r, acceptor_busy_r, srq_r, cfg_apply_r, dev_init_r;
  wire [1:0]  cfg_source_r;
  wire [3:0]  cfg_slot_r;
  integer     error_cnt = 0;
  integer     checked = 0;
  integer     cycles = 0;
  integer     i;
  always #4 clk = ~clk;
  gpib_ctrl_model i_gpib_ctrl_model (.clk(clk), .op(op), .go(go),
    .ifc(ifc), .dcl(dcl), .sdc(sdc));
  remote_init_ctrl i_remote_init_ctrl (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ifc(ifc), .dcl(dcl), .sdc(sdc), .listen_addr(listen_addr),
    .talk_addr(talk_addr), .msg_byte_in(msg_byte_in),
    .resp_byte_out(resp_byte_out),
    .ren(ren), .llo(llo), .local_key(local_key),
    .shipped_flag(shipped_flag), .mav_r(mav_r), .remote_r(remote_r),
    .talker_r(talker_r), .listener_r(listener_r),
    .acceptor_busy_r(acceptor_busy_r), .srq_r(srq_r),
    .cfg_apply_r(cfg_apply_r), .cfg_source_r(cfg_source_r),
    .cfg_slot_r(cfg_slot_r), .dev_init_r(dev_init_r));
  task complete_run;
    begin
      if (error_cnt == 0 && checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      error_cnt = error_cnt + 1;
      complete_run;
    end
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Request held until the edge that samples waitrequest low
  task bus_write(input [3:0] a, input [31:0] d);
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      avs_write <= 1'b0;
      @(posedge clk);
    end
  endtask
  task bus_read(input [3:0] a);
    begin
      avs_address <= a;
      avs_read <= 1'b1;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rd = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk);
    end
  endtask
  task cmd(input [1:0] o);
    begin
      op <= o;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      tick(2);
    end
  endtask
  task do_reset(input ship);
    begin
      rst_n <= 1'b0;
      shipped_flag <= ship;
      tick(6);
      rst_n <= 1'b1;
      i = 0;
      while (cfg_apply_r !== 1'b1 && i < 8) begin
        @(posedge clk);
        i = i + 1;
      end
    end
  endtask
  initial begin
    do_reset(1'b0);
    check({30'h0, cfg_source_r}, {30'h0, `SRC_FACTORY});
    bus_write(`OFS_CTRL, 32'h5100);
    do_reset(1'b1);
    check({30'h0, cfg_source_r}, {30'h0, `SRC_LAST});
    check({28'h0, cfg_slot_r}, 32'h5);
    bus_write(`OFS_CTRL, 32'h3000);
    do_reset(1'b1);
    check({30'h0, cfg_source_r}, {30'h0, `SRC_SLOT});
    check({28'h0, cfg_slot_r}, 32'h3);
    tick(2);
    bus_read(`OFS_STATUS);
    check(rd & 32'h7, 32'h6);
    bus_read(`OFS_ESR);
    check(rd, 32'h0);
    bus_read(`OFS_ESE);
    check(rd, 32'h0);
    bus_write(`OFS_ESE, 32'h55);
    bus_write(`OFS_CTRL, 32'h2);
    bus_write(`OFS_CTRL, 32'h4);
    bus_read(`OFS_STATUS);
    check(rd & 32'h1, 32'h1);
    bus_write(`OFS_CTRL, 32'h8);
    tick(3);
    bus_read(`OFS_STATUS);
    check(rd & 32'h1, 32'h1);
    bus_read(`OFS_ESE);
    check(rd, 32'h55);
    cmd(2'h1);
    bus_read(`OFS_STATUS);
    check(rd & 32'h7, 32'h6);
    bus_read(`OFS_ESE);
    check(rd, 32'h55);
    bus_write(`OFS_CTRL, 32'h2);
    bus_write(`OFS_CTRL, 32'h4);
    cmd(2'h2);
    bus_read(`OFS_STATUS);
    check(rd & 32'h1, 32'h1);
    msg_byte_in <= 1'b1;
    @(posedge clk);
    msg_byte_in <= 1'b0;
    tick(4);
    listen_addr <= 1'b1;
    tick(2);
    bus_read(`OFS_STATUS);
    check(rd & 32'h1, 32'h0);
    bus_write(`OFS_CTRL, 32'h2);
    bus_read(`OFS_STATUS);
    check(rd & 32'h1, 32'h1);
    cmd(2'h2);
    bus_read(`OFS_STATUS);
    check(rd & 32'h1, 32'h0);
    listen_addr <= 1'b0;
    bus_write(`OFS_CTRL, 32'h1);
    bus_write(`OFS_CTRL, 32'h4);
    bus_read(`OFS_ESR);
    check(rd & 32'h1, 32'h1);
    check({31'h0, srq_r}, 32'h1);
    bus_write(`OFS_ESR, 32'h1);
    bus_read(`OFS_ESR);
    check(rd & 32'h1, 32'h0);
    bus_write(`OFS_CTRL, 32'h8);
    bus_write(`OFS_CTRL, 32'h3);
    cmd(2'h1);
    bus_write(`OFS_CTRL, 32'h4);
    bus_read(`OFS_ESR);
    check(rd & 32'h1, 32'h0);
    bus_read(`OFS_STATUS);
    check(rd & 32'h7, 32'h6);
    bus_write(`OFS_CTRL, 32'h2);
    resp_byte_out <= 1'b1;
    @(posedge clk);
    resp_byte_out <= 1'b0;
    bus_read(`OFS_STATUS);
    check(rd & 32'h1, 32'h0);
    for (i = 0; i < 3; i = i + 1)
      bus_write(`OFS_CTRL, 32'h10 << i);
    tick(3);
    talk_addr <= 1'b1;
    listen_addr <= 1'b1;
    tick(3);
    cmd(2'h0);
    talk_addr <= 1'b0;
    ren <= 1'b1;
    llo <= 1'b1;
    tick(3);
    listen_addr <= 1'b0;
    local_key <= 1'b1;
    @(posedge clk);
    local_key <= 1'b0;
    tick(2);
    check({31'h0, remote_r}, 32'h1);
    ren <= 1'b0;
    llo <= 1'b0;
    tick(2);
    ren <= 1'b1;
    listen_addr <= 1'b1;
    @(posedge clk);
    listen_addr <= 1'b0;
    tick(2);
    check({31'h0, remote_r}, 32'h1);
    local_key <= 1'b1;
    @(posedge clk);
    local_key <= 1'b0;
    tick(2);
    check({31'h0, remote_r}, 32'h0);
    complete_run;
  end
endmodule
